// ==== ptq_defines.svh ====
/*
 * Constants of the trace trigger qualifier: register offsets, field
 * positions, reset values and trace memory sizing.
 * Assumes it is included by bare name from every design file.
 */
`ifndef PTQ_DEFINES_SVH
`define PTQ_DEFINES_SVH

// register offsets (byte addresses)
`define PTQ_CTRL_OFS 8'h00
`define PTQ_STATUS_OFS 8'h04
`define PTQ_SIG_OFS 8'h08
`define PTQ_CBE_OFS 8'h0C
`define PTQ_AD_OFS 8'h10
`define PTQ_BST_OFS 8'h14
`define PTQ_CMD_OFS 8'h18
`define PTQ_SQ_OFS 8'h1C
`define PTQ_ABS_OFS 8'h20
`define PTQ_RULE_EN_OFS 8'h24
`define PTQ_IRQ_STAT_OFS 8'h28
`define PTQ_IRQ_MASK_OFS 8'h2C
`define PTQ_VIOL_OFS 8'h30
`define PTQ_TR_ADDR_OFS 8'h34
`define PTQ_TR_LO_OFS 8'h38
`define PTQ_TR_HI_OFS 8'h3C

// control fields
`define PTQ_CTRL_ARM 0
`define PTQ_CTRL_PAT 1
`define PTQ_CTRL_ABS 2
`define PTQ_CTRL_SEL 3
`define PTQ_CTRL_NOIDLE 4
`define PTQ_CTRL_NOWAIT 5
`define PTQ_CTRL_MACT 8
`define PTQ_CTRL_TACT 10
`define PTQ_CTRL_RST 12'h000

// three-way test encodings
`define PTQ_TRI_LOW 2'b01
`define PTQ_TRI_HIGH 2'b10

// sampled single-bit positions
`define PTQ_SIG_FRAME 0
`define PTQ_SIG_IRDY 1
`define PTQ_SIG_TRDY 2
`define PTQ_SIG_MACT 6
`define PTQ_SIG_TACT 7

// interrupt status bits
`define PTQ_IRQ_TRIG 0
`define PTQ_IRQ_DONE 1
`define PTQ_IRQ_VIOL 2

// sizing and counts
`define PTQ_TERMS 3
`define PTQ_TERM_EN 24
`define PTQ_RULES 25
`define PTQ_RULE_EN_RST 25'h1FFFFFF
`define PTQ_DEPTH 256
`define PTQ_AW 8
`define PTQ_PTR_MAX 8'hFF
`define PTQ_POST_LAST 8'h7F
`define PTQ_ABS_SHIFT 8'h00

`endif

// ==== ptq_pkg.sv ====
/*
 * Types and shared decode functions of the trace trigger qualifier.
 * Assumes ptq_defines.svh is on the include path.
 */
`include "ptq_defines.svh"
`default_nettype none

package ptq_pkg;

	typedef enum logic [1:0] {
		PTQ_ST_IDLE = 2'b00,
		PTQ_ST_PRE = 2'b01,
		PTQ_ST_POST = 2'b10,
		PTQ_ST_DONE = 2'b11
	} ptq_state_t;

	// one sampled bus cycle as stored in the trace
	typedef struct packed {
		logic [7:0] sig;
		logic [3:0] cbe;
		logic [31:0] ad;
		logic [3:0] bst;
		logic [3:0] cmd;
	} ptq_sample_t;

	// any enabled term {care,val} matches the field
	function automatic logic term_any(input logic [26:0] cfg, input logic [3:0] f);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < `PTQ_TERMS; i++) begin
			if (cfg[`PTQ_TERM_EN + i] && (((f ^ cfg[8*i +: 4]) & cfg[8*i+4 +: 4]) == 4'h0)) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// must-be-high, must-be-low, else ignored
	function automatic logic tri_ok(input logic [1:0] sel, input logic v);
		return (sel == `PTQ_TRI_HIGH) ? v : ((sel == `PTQ_TRI_LOW) ? ~v : 1'b1);
	endfunction

endpackage

`default_nettype wire

// ==== ptq_mem_if.sv ====
/*
 * Write and read port bundle between the qualifier and its trace memory.
 * Assumes one clock shared by both ends.
 */
`include "ptq_defines.svh"
`default_nettype none

interface ptq_mem_if;
	import ptq_pkg::*;
	logic we;
	logic [`PTQ_AW-1:0] waddr;
	logic [`PTQ_AW-1:0] raddr;
	ptq_sample_t wdata;
	ptq_sample_t rdata;
	modport ctl(output we, output waddr, output raddr, output wdata, input rdata);
	modport mem(input we, input waddr, input raddr, input wdata, output rdata);
endinterface

`default_nettype wire

// ==== ptq_trace_mem.sv ====
/*
 * Trace memory: one write port, one registered read port.
 * Assumes addresses stable at the clock edge; no reset of contents.
 */
`include "ptq_defines.svh"
`default_nettype none

module ptq_trace_mem (
	input wire logic sys_clk_i,
	ptq_mem_if.mem mif
);
	import ptq_pkg::*;

	ptq_sample_t ram [0:`PTQ_DEPTH-1];

	// sample write
	always_ff @(posedge sys_clk_i) begin
		if (mif.we) begin
			ram[mif.waddr] <= mif.wdata;
		end
	end

	// registered read, one cycle behind raddr
	always_ff @(posedge sys_clk_i) begin
		mif.rdata <= ram[mif.raddr];
	end

endmodule

`default_nettype wire

// ==== ptq_pattern_cmp.sv ====
/*
 * Trigger pattern comparator, purely combinational.
 * Assumes the sample and all settings come from flops of one clock.
 */
`include "ptq_defines.svh"
`default_nettype none

module ptq_pattern_cmp (
	input wire ptq_pkg::ptq_sample_t smp_i,
	input wire logic [7:0] sig_val_i,
	input wire logic [7:0] sig_care_i,
	input wire logic [3:0] cbe_val_i,
	input wire logic [3:0] cbe_care_i,
	input wire logic [31:0] ad_val_i,
	input wire logic [5:0] ad_dc_i,
	input wire logic [26:0] bst_cfg_i,
	input wire logic [26:0] cmd_cfg_i,
	output logic match_o
);
	import ptq_pkg::*;

	logic sig_hit;
	logic cbe_hit;
	logic ad_hit;
	logic [31:0] ad_care;

	assign sig_hit = ((smp_i.sig ^ sig_val_i) & sig_care_i) == 8'h00;
	assign cbe_hit = ((smp_i.cbe ^ cbe_val_i) & cbe_care_i) == 4'h0;
	// only low ad bits may be masked
	assign ad_care = 32'hFFFFFFFF << ad_dc_i;
	assign ad_hit = ((smp_i.ad ^ ad_val_i) & ad_care) == 32'h00000000;

	// ORed terms on state and command
	assign match_o = sig_hit & cbe_hit & ad_hit & term_any(bst_cfg_i, smp_i.bst)
		& term_any(cmd_cfg_i, smp_i.cmd);

endmodule

`default_nettype wire

// ==== ptq_top.sv ====
/*
 * Trace trigger and storage qualifier with APB register slave.
 * Samples bus pins and own state flags every clock, triggers, stores
 * qualified cycles into a trace memory, gates protocol violations.
 * Assumes bus pins asynchronous to sys_clk_i; APB on sys_clk_i.
 */
// The implementer's own choices: the APB register port and the register offsets.
`include "ptq_defines.svh"
`default_nettype none

module ptq_top (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic pci_frame_n_i,
	input wire logic pci_irdy_n_i,
	input wire logic pci_trdy_n_i,
	input wire logic pci_devsel_n_i,
	input wire logic pci_stop_n_i,
	input wire logic pci_par_i,
	input wire logic [3:0] command_byte_enable_field_i,
	input wire logic [31:0] address_data_field_i,
	input wire logic m_act_i,
	input wire logic t_act_i,
	input wire logic [3:0] bus_state_i,
	input wire logic [3:0] xact_cmd_i,
	input wire logic [`PTQ_RULES-1:0] rule_viol_i,
	output logic irq_o,
	output logic trig_o,
	output logic viol_o
);
	import ptq_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	ptq_sample_t raw;
	ptq_sample_t smp_meta_reg;
	ptq_sample_t smp;
	logic [`PTQ_RULES-1:0] viol_meta_reg;
	logic [`PTQ_RULES-1:0] viol_sync_reg;

	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] rd_mux;
	logic mapped;
	logic acc;
	logic wr_en;
	logic arm;

	logic [11:0] ctrl_reg;
	logic [15:0] sig_cfg_reg;
	logic [13:0] cbe_cfg_reg;
	logic [31:0] ad_val_reg;
	logic [26:0] bst_cfg_reg;
	logic [26:0] cmd_cfg_reg;
	logic [26:0] sq_cfg_reg;
	logic [15:0] abs_reg;
	logic [`PTQ_RULES-1:0] rule_en_reg;
	logic [2:0] irq_mask_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_stat_next;
	logic [`PTQ_RULES-1:0] viol_stat_reg;
	logic [`PTQ_AW-1:0] rd_ptr_reg;

	ptq_state_t st_reg;
	logic [`PTQ_AW-1:0] wr_ptr_reg;
	logic [`PTQ_AW-1:0] trig_addr_reg;
	logic [7:0] post_cnt_reg;
	logic wrapped_reg;
	logic seen_reg;
	logic [23:0] gap_cnt_reg;
	logic [23:0] limit;

	logic match;
	logic trig_fire;
	logic done_ev;
	logic viol_ev;
	logic idle_cyc;
	logic wait_cyc;
	logic qual_ok;
	logic store_ok;
	logic irq_reg;
	logic viol_reg;

	ptq_mem_if mif();

	////////////////////////////////////////////////////////////////////////
	// input sampling

	assign raw = '{
		sig: {t_act_i, m_act_i, pci_par_i, pci_stop_n_i, pci_devsel_n_i,
			pci_trdy_n_i, pci_irdy_n_i, pci_frame_n_i},
		cbe: command_byte_enable_field_i,
		ad: address_data_field_i,
		bst: bus_state_i,
		cmd: xact_cmd_i
	};

	// two stages for every input; own flags ride along to stay aligned
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			smp_meta_reg <= '0;
			smp <= '0;
			viol_meta_reg <= '0;
			viol_sync_reg <= '0;
		end else begin
			smp_meta_reg <= raw;
			smp <= smp_meta_reg;
			viol_meta_reg <= rule_viol_i;
			viol_sync_reg <= viol_meta_reg;
		end
	end

	// idle: frame and irdy both deasserted; wait: active but not both ready
	assign idle_cyc = smp.sig[`PTQ_SIG_FRAME] & smp.sig[`PTQ_SIG_IRDY];
	assign wait_cyc = ~idle_cyc & (smp.sig[`PTQ_SIG_IRDY] | smp.sig[`PTQ_SIG_TRDY]);

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, so prdata is a flop

	assign acc = psel_i & penable_i & pready_reg;
	assign wr_en = acc & pwrite_i;
	assign arm = wr_en && (paddr_i == `PTQ_CTRL_OFS) && pwdata_i[`PTQ_CTRL_ARM];

	// read decode
	always_comb begin
		rd_mux = 32'h00000000;
		mapped = 1'b1;
		case (paddr_i)
			`PTQ_CTRL_OFS: rd_mux = {20'h00000, ctrl_reg};
			`PTQ_STATUS_OFS: rd_mux = {8'h00, wr_ptr_reg, trig_addr_reg, 5'h00, wrapped_reg,
				st_reg};
			`PTQ_SIG_OFS: rd_mux = {16'h0000, sig_cfg_reg};
			`PTQ_CBE_OFS: rd_mux = {18'h00000, cbe_cfg_reg};
			`PTQ_AD_OFS: rd_mux = ad_val_reg;
			`PTQ_BST_OFS: rd_mux = {5'h00, bst_cfg_reg};
			`PTQ_CMD_OFS: rd_mux = {5'h00, cmd_cfg_reg};
			`PTQ_SQ_OFS: rd_mux = {5'h00, sq_cfg_reg};
			`PTQ_ABS_OFS: rd_mux = {16'h0000, abs_reg};
			`PTQ_RULE_EN_OFS: rd_mux = {7'h00, rule_en_reg};
			`PTQ_IRQ_STAT_OFS: rd_mux = {29'h00000000, irq_stat_reg};
			`PTQ_IRQ_MASK_OFS: rd_mux = {29'h00000000, irq_mask_reg};
			`PTQ_VIOL_OFS: rd_mux = {7'h00, viol_stat_reg};
			`PTQ_TR_ADDR_OFS: rd_mux = {24'h000000, rd_ptr_reg};
			`PTQ_TR_LO_OFS: rd_mux = mif.rdata.ad;
			`PTQ_TR_HI_OFS: rd_mux = {12'h000, mif.rdata.cmd, mif.rdata.bst, mif.rdata.cbe,
				mif.rdata.sig};
			default: mapped = 1'b0;
		endcase
	end

	// answer one cycle into the access phase
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else begin
			pready_reg <= psel_i & penable_i & ~pready_reg;
			pslverr_reg <= psel_i & penable_i & ~pready_reg & ~mapped;
			if (psel_i & penable_i & ~pready_reg) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= `PTQ_CTRL_RST;
			sig_cfg_reg <= 16'h0000;
			cbe_cfg_reg <= 14'h0000;
			ad_val_reg <= 32'h00000000;
			bst_cfg_reg <= 27'h0000000;
			cmd_cfg_reg <= 27'h0000000;
			sq_cfg_reg <= 27'h0000000;
			abs_reg <= 16'h0000;
			rule_en_reg <= `PTQ_RULE_EN_RST;
			irq_mask_reg <= 3'h0;
		end else if (wr_en) begin
			case (paddr_i)
				`PTQ_CTRL_OFS: ctrl_reg <= {pwdata_i[11:1], 1'b0};
				`PTQ_SIG_OFS: sig_cfg_reg <= pwdata_i[15:0];
				`PTQ_CBE_OFS: cbe_cfg_reg <= pwdata_i[13:0];
				`PTQ_AD_OFS: ad_val_reg <= pwdata_i;
				`PTQ_BST_OFS: bst_cfg_reg <= pwdata_i[26:0];
				`PTQ_CMD_OFS: cmd_cfg_reg <= pwdata_i[26:0];
				`PTQ_SQ_OFS: sq_cfg_reg <= pwdata_i[26:0];
				`PTQ_ABS_OFS: abs_reg <= pwdata_i[15:0];
				// per-rule enables, all at once by writing all ones or zeros
				`PTQ_RULE_EN_OFS: rule_en_reg <= pwdata_i[`PTQ_RULES-1:0];
				`PTQ_IRQ_MASK_OFS: irq_mask_reg <= pwdata_i[2:0];
				default: ;
			endcase
		end
	end

	// trace read pointer; reading the high word steps to the next sample
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rd_ptr_reg <= 8'h00;
		end else if (wr_en && (paddr_i == `PTQ_TR_ADDR_OFS)) begin
			rd_ptr_reg <= pwdata_i[`PTQ_AW-1:0];
		end else if (acc && !pwrite_i && (paddr_i == `PTQ_TR_HI_OFS)) begin
			rd_ptr_reg <= rd_ptr_reg + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger

	ptq_pattern_cmp u_cmp (
		.smp_i(smp),
		.sig_val_i(sig_cfg_reg[7:0]),
		.sig_care_i(sig_cfg_reg[15:8]),
		.cbe_val_i(cbe_cfg_reg[3:0]),
		.cbe_care_i(cbe_cfg_reg[7:4]),
		.ad_val_i(ad_val_reg),
		.ad_dc_i(cbe_cfg_reg[13:8]),
		.bst_cfg_i(bst_cfg_reg),
		.cmd_cfg_i(cmd_cfg_reg),
		.match_o(match)
	);

	// window is a whole number of 256-cycle units
	assign limit = {abs_reg, `PTQ_ABS_SHIFT};

	always_comb begin
		trig_fire = 1'b0;
		if (st_reg == PTQ_ST_PRE) begin
			if (!ctrl_reg[`PTQ_CTRL_PAT]) begin
				trig_fire = 1'b1;
			end else if (!ctrl_reg[`PTQ_CTRL_ABS]) begin
				trig_fire = match;
			end else begin
				trig_fire = seen_reg && !match && (limit != 24'h000000)
					&& (gap_cnt_reg == limit - 24'h000001);
			end
		end
	end

	// cycles since the last match; a zero window never fires
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || arm) begin
			seen_reg <= 1'b0;
			gap_cnt_reg <= 24'h000000;
		end else if (match) begin
			seen_reg <= 1'b1;
			gap_cnt_reg <= 24'h000000;
		end else if (seen_reg) begin
			gap_cnt_reg <= gap_cnt_reg + 24'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// storage qualifier

	assign qual_ok = tri_ok(ctrl_reg[`PTQ_CTRL_MACT +: 2], smp.sig[`PTQ_SIG_MACT])
		& tri_ok(ctrl_reg[`PTQ_CTRL_TACT +: 2], smp.sig[`PTQ_SIG_TACT])
		& term_any(sq_cfg_reg, smp.cmd);

	// all cycles or selected ones, minus idle and wait if asked
	assign store_ok = (~ctrl_reg[`PTQ_CTRL_SEL] | qual_ok)
		& ~(ctrl_reg[`PTQ_CTRL_NOIDLE] & idle_cyc)
		& ~(ctrl_reg[`PTQ_CTRL_NOWAIT] & wait_cyc);

	// pre-trigger history is unfiltered so the lead-up is complete
	assign mif.we = (st_reg == PTQ_ST_PRE) | ((st_reg == PTQ_ST_POST) & store_ok);
	assign mif.waddr = wr_ptr_reg;
	assign mif.wdata = smp;
	assign mif.raddr = rd_ptr_reg;

	ptq_trace_mem u_mem (
		.sys_clk_i(sys_clk_i),
		.mif(mif)
	);

	assign done_ev = (st_reg == PTQ_ST_POST) && mif.we && (post_cnt_reg == `PTQ_POST_LAST);

	// capture sequence
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			st_reg <= PTQ_ST_IDLE;
			post_cnt_reg <= 8'h00;
			trig_addr_reg <= 8'h00;
		end else if (arm) begin
			st_reg <= PTQ_ST_PRE;
			post_cnt_reg <= 8'h00;
		end else begin
			unique case (st_reg)
				PTQ_ST_IDLE: st_reg <= PTQ_ST_IDLE;
				PTQ_ST_PRE: begin
					// trigger sample address kept for relative numbering
					if (trig_fire) begin
						st_reg <= PTQ_ST_POST;
						trig_addr_reg <= wr_ptr_reg;
					end
				end
				PTQ_ST_POST: begin
					if (mif.we) begin
						post_cnt_reg <= post_cnt_reg + 8'h01;
					end
					if (done_ev) begin
						st_reg <= PTQ_ST_DONE;
					end
				end
				PTQ_ST_DONE: st_reg <= PTQ_ST_DONE;
			endcase
		end
	end

	// write pointer; wrap flag says writes, pre- or post-trigger, went past the ring's last entry
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || arm) begin
			wr_ptr_reg <= 8'h00;
			wrapped_reg <= 1'b0;
		end else if (mif.we) begin
			wr_ptr_reg <= wr_ptr_reg + 8'h01;
			if (wr_ptr_reg == `PTQ_PTR_MAX) begin
				wrapped_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// violations and interrupts

	assign viol_ev = |(viol_sync_reg & rule_en_reg);

	// write-one-to-clear; a new event in the same cycle wins
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_en && (paddr_i == `PTQ_IRQ_STAT_OFS)) begin
			irq_stat_next = irq_stat_reg & ~pwdata_i[2:0];
		end
		irq_stat_next[`PTQ_IRQ_TRIG] = irq_stat_next[`PTQ_IRQ_TRIG] | trig_fire;
		irq_stat_next[`PTQ_IRQ_DONE] = irq_stat_next[`PTQ_IRQ_DONE] | done_ev;
		irq_stat_next[`PTQ_IRQ_VIOL] = irq_stat_next[`PTQ_IRQ_VIOL] | viol_ev;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			irq_stat_reg <= 3'h0;
			irq_reg <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// sticky per-rule record, same set-wins clear
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			viol_stat_reg <= '0;
			viol_reg <= 1'b0;
		end else begin
			viol_reg <= viol_ev;
			if (wr_en && (paddr_i == `PTQ_VIOL_OFS)) begin
				viol_stat_reg <= (viol_stat_reg & ~pwdata_i[`PTQ_RULES-1:0])
					| (viol_sync_reg & rule_en_reg);
			end else begin
				viol_stat_reg <= viol_stat_reg | (viol_sync_reg & rule_en_reg);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign irq_o = irq_reg;
	assign viol_o = viol_reg;
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			trig_o <= 1'b0;
		end else begin
			trig_o <= (st_reg == PTQ_ST_POST) || (st_reg == PTQ_ST_DONE);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_immediate_trig: assert property (
		(st_reg == PTQ_ST_PRE && !ctrl_reg[`PTQ_CTRL_PAT] && !arm) |=> st_reg == PTQ_ST_POST)
		else $error("immediate trigger did not fire");

	chk_sig_care: assert property (
		match |-> ((smp.sig ^ sig_cfg_reg[7:0]) & sig_cfg_reg[15:8]) == 8'h00)
		else $error("pattern matched with a cared bit wrong");

	chk_ad_low_mask: assert property (
		match |-> ((smp.ad ^ ad_val_reg) & (32'hFFFFFFFF << cbe_cfg_reg[13:8])) == 32'h00000000)
		else $error("address field matched outside masked low bits");

	chk_cmd_terms: assert property (
		match |-> term_any(cmd_cfg_reg, smp.cmd) && term_any(bst_cfg_reg, smp.bst))
		else $error("pattern matched with no term hit");

	chk_first_match: assert property (
		(st_reg == PTQ_ST_PRE && ctrl_reg[`PTQ_CTRL_PAT] && !ctrl_reg[`PTQ_CTRL_ABS]
			&& !arm) |-> (match == trig_fire) ##1 ($past(match) ? st_reg == PTQ_ST_POST :
			st_reg == $past(st_reg)))
		else $error("pattern trigger not on first match");

	chk_absence_hold: assert property (
		(st_reg == PTQ_ST_PRE && ctrl_reg[`PTQ_CTRL_ABS] && ctrl_reg[`PTQ_CTRL_PAT]
			&& match && !arm) |=> st_reg == PTQ_ST_PRE && gap_cnt_reg == 24'h000000)
		else $error("absence trigger fired on a match");

	chk_store_all: assert property (
		(st_reg == PTQ_ST_POST && ctrl_reg[5:3] == 3'b000) |-> mif.we)
		else $error("cycle dropped while storing all");

	chk_mact_qual: assert property (
		(st_reg == PTQ_ST_POST && ctrl_reg[`PTQ_CTRL_SEL]
			&& ctrl_reg[`PTQ_CTRL_MACT +: 2] == `PTQ_TRI_HIGH && !smp.sig[`PTQ_SIG_MACT])
			|-> !mif.we)
		else $error("stored with initiator inactive");

	chk_tact_qual: assert property (
		(st_reg == PTQ_ST_POST && ctrl_reg[`PTQ_CTRL_SEL]
			&& ctrl_reg[`PTQ_CTRL_TACT +: 2] == `PTQ_TRI_LOW && smp.sig[`PTQ_SIG_TACT])
			|-> !mif.we)
		else $error("stored with responder active");

	chk_sq_cmd: assert property (
		(st_reg == PTQ_ST_POST && ctrl_reg[`PTQ_CTRL_SEL] && mif.we)
			|-> term_any(sq_cfg_reg, smp.cmd))
		else $error("stored a command that no term selects");

	chk_idle_drop: assert property (
		(st_reg == PTQ_ST_POST && ((ctrl_reg[`PTQ_CTRL_NOIDLE] && idle_cyc)
			|| (ctrl_reg[`PTQ_CTRL_NOWAIT] && wait_cyc))) |-> !mif.we)
		else $error("suppressed idle or wait cycle stored");

	chk_rule_gate: assert property (
		##1 viol_o == |($past(viol_sync_reg) & $past(rule_en_reg)))
		else $error("violation report does not follow rule enables");

	chk_trig_pos: assert property (
		(trig_fire && !arm) |=> trig_addr_reg == $past(wr_ptr_reg)
			&& wr_ptr_reg == $past(wr_ptr_reg) + 8'h01)
		else $error("trigger position not recorded");

endmodule

`default_nettype wire

// ==== ptq_pci_agent.sv ====
/*
 * Observed bus traffic: one command phase and one data phase per go pulse,
 * the data phase with one target wait state.
 * Assumes go_i is pulsed for one cycle while the agent is idle.
 */
`default_nettype none
module ptq_pci_agent (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [3:0] cmd_i,
	output logic frame_n_o,
	output logic irdy_n_o,
	output logic trdy_n_o,
	output logic devsel_n_o,
	output logic par_o,
	output logic [3:0] cbe_o,
	output logic [31:0] ad_o,
	output logic m_act_o,
	output logic [3:0] bst_o,
	output logic [3:0] cmd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] st = 2'd0;
	logic [7:0] cnt = 8'h00;
	// phase counter; released ad/cbe churn so stale values never look held
	always @(posedge clk_i) begin
		st <= go_i ? 2'd1 : ((st == 2'd3) ? 2'd0 : st + {1'b0, st != 2'd0});
		cnt <= cnt + 8'h01;
	end
	// control lines idle high through their pull-ups
	assign frame_n_o = !(st == 2'd1 || st == 2'd2);
	assign irdy_n_o = st < 2'd2;
	assign trdy_n_o = st != 2'd3;
	assign devsel_n_o = st < 2'd2;
	assign ad_o = (st == 2'd1) ? 32'h000B8000 : ((st != 2'd0) ? 32'h8F458F42 : {4{cnt}});
	assign cbe_o = (st == 2'd1) ? cmd_i : ((st != 2'd0) ? 4'h0 : cnt[3:0]);
	assign par_o = ^{ad_o, cbe_o};
	assign m_act_o = st != 2'd0;
	assign bst_o = {2'b00, st};
	assign cmd_o = cmd_i;
endmodule
`default_nettype wire

// ==== ptq_top_tb_top.sv ====
/*
 * Self-checking bench of the trace trigger qualifier.
 * Assumes the agent model in ptq_pci_agent.sv and the design defines.
 */
`include "ptq_defines.svh"
`default_nettype none
module ptq_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0, err;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0, rd, st0;
	logic [3:0] cmd = 4'h0;
	logic [24:0] viol = 25'h0;
	int n_fail = 0, samples_checked = 0;
	wire logic [31:0] prd, ad;
	wire logic rdy, slv, irq, trig, vio, fr, ir, tr, dv, par, ma;
	wire logic [3:0] cbe, bst, xc;
	logic [31:0] ctl_t [4] = '{32'h019, 32'h229, 32'h809, 32'h209};
	logic [31:0] sq_t [4] = '{32'h01000000, 32'h01000000, 32'h01000000, 32'h010000F3};
	logic [7:0] exp_t [4] = '{8'h03, 8'h01, 8'h02, 8'h00};
	////////////////////////////////////////////////////////////////////////////////////////
	ptq_top u_ptq_top (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
		.pslverr_o(slv), .pci_frame_n_i(fr), .pci_irdy_n_i(ir), .pci_trdy_n_i(tr),
		.pci_devsel_n_i(dv), .pci_stop_n_i(1'b1), .pci_par_i(par),
		.command_byte_enable_field_i(cbe), .address_data_field_i(ad), .m_act_i(ma),
		.t_act_i(~dv), .bus_state_i(bst), .xact_cmd_i(xc), .rule_viol_i(viol),
		.irq_o(irq), .trig_o(trig), .viol_o(vio));
	ptq_pci_agent u_ptq_pci_agent (.clk_i(clk), .go_i(go), .cmd_i(cmd), .frame_n_o(fr),
		.irdy_n_o(ir), .trdy_n_o(tr), .devsel_n_o(dv), .par_o(par), .cbe_o(cbe), .ad_o(ad),
		.m_act_o(ma), .bst_o(bst), .cmd_o(xc));
	////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// no fixed wait count: only the watchdog may end a stuck access
		do @(posedge clk); while (rdy !== 1'b1);
		rd = prd;
		err = slv;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic txn(input logic [3:0] c);
		@(posedge clk);
		go <= 1'b1;
		cmd <= c;
		@(posedge clk);
		go <= 1'b0;
		cyc(8);
	endtask
	task automatic give_verdict();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		apb(1'b0, `PTQ_CTRL_OFS, 32'h0);
		chk("ctrl", 32'h0, rd);
		apb(1'b0, `PTQ_RULE_EN_OFS, 32'h0);
		chk("rule_en", 32'h01FFFFFF, rd);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
	endtask
	task automatic t_immediate();
		apb(1'b1, `PTQ_CTRL_OFS, 32'h1);
		cyc(6);
		chk("trig", 32'h1, {31'h0, trig});
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `PTQ_IRQ_MASK_OFS, 32'h1);
		cyc(3);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, `PTQ_IRQ_STAT_OFS, 32'h7);
		cyc(3);
		chk("irq clr", 32'h0, {31'h0, irq});
		cyc(140);
		apb(1'b0, `PTQ_STATUS_OFS, 32'h0);
		chk("done", 32'h3, rd & 32'h3);
	endtask
	// frame low, ad 000B80xx, command 3 or 7
	task automatic t_pattern();
		apb(1'b1, `PTQ_SIG_OFS, 32'h100);
		apb(1'b1, `PTQ_CBE_OFS, 32'h800);
		apb(1'b1, `PTQ_AD_OFS, 32'h000B80FF);
		apb(1'b1, `PTQ_BST_OFS, 32'h01000000);
		apb(1'b1, `PTQ_CMD_OFS, 32'h0300F7F3);
		apb(1'b1, `PTQ_CTRL_OFS, 32'h3);
		cmd <= 4'h7;
		cyc(8);
		chk("trig", 32'h0, {31'h0, trig});
		txn(4'h6);
		chk("trig", 32'h0, {31'h0, trig});
		txn(4'h7);
		chk("trig", 32'h1, {31'h0, trig});
		// every pre-trigger cycle since arm is stored, so the match lands at 22
		apb(1'b0, `PTQ_STATUS_OFS, 32'h0);
		chk("trig addr", 32'h00000016, {24'h0, rd[15:8]});
		apb(1'b1, `PTQ_TR_ADDR_OFS, {24'h0, rd[15:8]});
		apb(1'b0, `PTQ_TR_LO_OFS, 32'h0);
		chk("trig sample", 32'h000B8000, rd);
	endtask
	task automatic t_absence();
		apb(1'b1, `PTQ_ABS_OFS, 32'h1);
		apb(1'b1, `PTQ_CTRL_OFS, 32'h7);
		txn(4'h7);
		cyc(200);
		chk("trig early", 32'h0, {31'h0, trig});
		for (int k = 0; k < 100 && trig !== 1'b1; k++) @(posedge clk);
		chk("trig", 32'h1, {31'h0, trig});
	endtask
	task automatic t_store();
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `PTQ_SQ_OFS, sq_t[i]);
			apb(1'b1, `PTQ_CTRL_OFS, ctl_t[i]);
			cyc(4);
			apb(1'b0, `PTQ_STATUS_OFS, 32'h0);
			st0 = rd;
			txn(4'h7);
			apb(1'b0, `PTQ_STATUS_OFS, 32'h0);
			st0 = {24'h0, rd[23:16] - st0[23:16]};
			chk("stored", {24'h0, exp_t[i]}, st0);
		end
	endtask
	task automatic t_viol();
		viol <= 25'h10;
		cyc(5);
		chk("viol", 32'h1, {31'h0, vio});
		apb(1'b1, `PTQ_RULE_EN_OFS, 32'h01FFFFEF);
		cyc(3);
		chk("viol masked", 32'h0, {31'h0, vio});
		apb(1'b1, `PTQ_RULE_EN_OFS, 32'h0);
		cyc(3);
		chk("viol off", 32'h0, {31'h0, vio});
		apb(1'b1, `PTQ_RULE_EN_OFS, 32'h01FFFFFF);
		cyc(3);
		chk("viol all on", 32'h1, {31'h0, vio});
	endtask
	////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(3);
		rst_n <= 1'b1;
		t_reset();
		t_immediate();
		t_pattern();
		t_absence();
		t_store();
		t_viol();
		give_verdict();
	end
	// hang guard, far beyond the fewer than a thousand cycles the run needs
	initial begin
		cyc(6000);
		n_fail++;
		give_verdict();
	end
endmodule
`default_nettype wire
